// file: src/can_ext_id_defs.vh
`ifndef CAN_EXT_ID_DEFS_VH
`define CAN_EXT_ID_DEFS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_TX_BYTE0 6'h00
`define ADDR_TX_BYTE1 6'h04
`define ADDR_TX_BYTE2 6'h08
`define ADDR_TX_BYTE3 6'h0c
`define ADDR_RX_BYTE0 6'h10
`define ADDR_RX_BYTE1 6'h14
`define ADDR_RX_BYTE2 6'h18
`define ADDR_RX_BYTE3 6'h1c
`define ADDR_CTRL 6'h20
`define ADDR_STATUS 6'h24
// ****************************************
// Control and status fields
// ****************************************
`define CTRL_QUEUE_BIT 0
`define CTRL_SELECT_BIT 1
`define CTRL_RX_RELEASE_BIT 2
`define CTRL_ARB_CLEAR_BIT 3
`define STAT_TX_EMPTY_BIT 0
`define STAT_RX_FULL_BIT 1
`define STAT_ARB_LOST_BIT 2
`define STAT_TX_ACTIVE_BIT 3
// ****************************************
// Identifier byte fields
// ****************************************
`define IDB1_SRR_BIT 4
`define IDB1_IDE_BIT 3
`define IDB3_RTR_BIT 0
`define IDE_STANDARD 1'b0
`define IDE_EXTENDED 1'b1
`define RTR_DATA 1'b0
`define RTR_REMOTE 1'b1
`define SRR_RECESSIVE 1'b1
// ****************************************
// Arbitration field lengths in bits
// ****************************************
`define EXT_FIELD_LEN 6'h20
`define STD_FIELD_LEN 6'h0d
`define IDE_POS_IN_FIELD 6'h0d
`define STD_PAD_BITS 19
// ****************************************
// Reset values of control state
// ****************************************
`define RST_TX_EMPTY 1'b1
`define RST_SELECT 1'b0
`define RST_WAIT 1'b1
`endif

// file: src/can_ext_id_buffer.v
`include "can_ext_id_defs.vh"
`default_nettype none

module can_ext_id_buffer (
   input wire sys_clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire [5:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   input wire tx_start_i,
   input wire tx_shift_i,
   input wire tx_bus_bit_i,
   input wire tx_done_i,
   output reg tx_request_o,
   output reg tx_bit_o,
   output reg tx_last_o,
   output reg tx_active_o,
   output reg arb_lost_o,
   input wire rx_start_i,
   input wire rx_bit_valid_i,
   input wire rx_bit_i,
   output reg rx_full_o
);

   // ****************************************
   // Storage and control state
   // ****************************************
   reg [7:0] tx_id_reg [0:3];
   reg [31:0] rx_id_reg;
   reg tx_buffer_empty_flag;
   reg tx_buffer_select_reg;
   reg [31:0] tx_shift_reg;
   reg [5:0] tx_count_reg;
   reg [31:0] rx_shift_reg;
   reg [5:0] rx_count_reg;
   reg [5:0] rx_len_reg;
   reg rx_busy_reg;

   wire bus_req;
   wire bus_take;
   wire wr_take;
   wire lane0;
   wire tx_open;
   wire [31:0] tx_field;
   wire [5:0] tx_len;
   wire tx_loses;
   wire rx_last;
   wire [5:0] rx_len_eff;
   wire [31:0] rx_shift_next;
   wire [31:0] rx_aligned;
   wire ctrl_wr;
   wire queue_req;
   wire rx_release;
   wire arb_clear;
   wire rx_done;
   reg [31:0] read_next;

   assign bus_req = avs_read_i | avs_write_i;
   assign bus_take = bus_req & ~avs_waitrequest_o;
   assign wr_take = avs_write_i & ~avs_waitrequest_o;
   assign lane0 = avs_byteenable_i[0];
   assign ctrl_wr = wr_take & lane0 & (avs_address_i == `ADDR_CTRL);

   // Buffer writable only while empty and selected
   assign tx_open = tx_buffer_empty_flag & tx_buffer_select_reg;

   // ****************************************
   // Avalon handshake
   // ****************************************
   // One wait cycle per access, answer in the next
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= `RST_WAIT;
      end else if (ce_i) begin
         avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
      end
   end

   always @* begin
      read_next = 32'h0000_0000;
      case (avs_address_i)
         `ADDR_TX_BYTE0: read_next[7:0] = tx_id_reg[0];
         `ADDR_TX_BYTE1: read_next[7:0] = tx_id_reg[1];
         `ADDR_TX_BYTE2: read_next[7:0] = tx_id_reg[2];
         `ADDR_TX_BYTE3: read_next[7:0] = tx_id_reg[3];
         `ADDR_RX_BYTE0: read_next[7:0] = rx_id_reg[31:24];
         `ADDR_RX_BYTE1: read_next[7:0] = rx_id_reg[23:16];
         `ADDR_RX_BYTE2: read_next[7:0] = rx_id_reg[15:8];
         `ADDR_RX_BYTE3: read_next[7:0] = rx_id_reg[7:0];
         `ADDR_CTRL: read_next[`CTRL_SELECT_BIT] = tx_buffer_select_reg;
         `ADDR_STATUS: begin
            read_next[`STAT_TX_EMPTY_BIT] = tx_buffer_empty_flag;
            read_next[`STAT_RX_FULL_BIT] = rx_full_o;
            read_next[`STAT_ARB_LOST_BIT] = arb_lost_o;
            read_next[`STAT_TX_ACTIVE_BIT] = tx_active_o;
         end
         default: read_next = 32'h0000_0000;
      endcase
   end

   // Read data captured in the wait cycle, valid when waitrequest drops
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (ce_i) begin
         if (avs_read_i & avs_waitrequest_o) begin
            avs_readdata_o <= read_next;
         end
      end
   end

   // ****************************************
   // Transmit identifier bytes
   // ****************************************
   // No reset: contents undefined until written
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_tx_byte
         always @(posedge sys_clk_i) begin
            if (ce_i & wr_take & lane0 & tx_open & (avs_address_i == (gi * 4))) begin
               tx_id_reg[gi] <= avs_writedata_i[7:0];
            end
         end
      end
   endgenerate

   // ****************************************
   // Control register and flags
   // ****************************************
   assign queue_req = ctrl_wr & avs_writedata_i[`CTRL_QUEUE_BIT] & tx_open;
   assign rx_release = ctrl_wr & avs_writedata_i[`CTRL_RX_RELEASE_BIT];
   assign arb_clear = ctrl_wr & avs_writedata_i[`CTRL_ARB_CLEAR_BIT];

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_buffer_select_reg <= `RST_SELECT;
         tx_buffer_empty_flag <= `RST_TX_EMPTY;
         tx_request_o <= 1'b0;
      end else if (ce_i) begin
         if (ctrl_wr) begin
            tx_buffer_select_reg <= avs_writedata_i[`CTRL_SELECT_BIT];
         end
         // Completion sets empty and wins over a queue request
         if (tx_done_i) begin
            tx_buffer_empty_flag <= 1'b1;
            tx_request_o <= 1'b0;
         end else if (queue_req) begin
            tx_buffer_empty_flag <= 1'b0;
            tx_request_o <= 1'b1;
         end
      end
   end

   // ****************************************
   // Transmit serialiser
   // ****************************************
   // Byte layout is already the on-bus arbitration order
   assign tx_field = {tx_id_reg[0], tx_id_reg[1], tx_id_reg[2], tx_id_reg[3]};
   assign tx_len = (tx_id_reg[1][`IDB1_IDE_BIT] == `IDE_EXTENDED) ?
                   `EXT_FIELD_LEN : `STD_FIELD_LEN;
   // Recessive sent, dominant seen: a smaller id won
   assign tx_loses = tx_bit_o & ~tx_bus_bit_i;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_shift_reg <= 32'h0000_0000;
         tx_count_reg <= 6'h00;
         tx_active_o <= 1'b0;
         tx_bit_o <= 1'b1;
         tx_last_o <= 1'b0;
      end else if (ce_i) begin
         if (tx_start_i & tx_request_o & ~tx_active_o) begin
            tx_shift_reg <= {tx_field[30:0], 1'b0};
            tx_bit_o <= tx_field[31];
            tx_count_reg <= tx_len - 6'h01;
            tx_last_o <= 1'b0;
            tx_active_o <= 1'b1;
         end else if (tx_active_o & tx_shift_i) begin
            if (tx_loses | (tx_count_reg == 6'h00)) begin
               tx_active_o <= 1'b0;
               tx_bit_o <= 1'b1;
               tx_last_o <= 1'b0;
            end else begin
               // SRR, IDE and RTR leave in place as written
               tx_bit_o <= tx_shift_reg[31];
               tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
               tx_count_reg <= tx_count_reg - 6'h01;
               tx_last_o <= (tx_count_reg == 6'h01);
            end
         end
      end
   end

   // Lost arbitration flag, set wins over clear
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         arb_lost_o <= 1'b0;
      end else if (ce_i) begin
         if (tx_active_o & tx_shift_i & tx_loses) begin
            arb_lost_o <= 1'b1;
         end else if (arb_clear) begin
            arb_lost_o <= 1'b0;
         end
      end
   end

   // ****************************************
   // Receive deserialiser
   // ****************************************
   assign rx_shift_next = {rx_shift_reg[30:0], rx_bit_i};
   // Extension flag bit decides the length in its own cycle
   // A standard field ends on that same bit
   assign rx_len_eff = ((rx_count_reg + 6'h01) == `IDE_POS_IN_FIELD) ?
                       ((rx_bit_i == `IDE_EXTENDED) ? `EXT_FIELD_LEN : `STD_FIELD_LEN) :
                       rx_len_reg;
   assign rx_last = (rx_count_reg + 6'h01) == rx_len_eff;
   assign rx_done = rx_busy_reg & rx_bit_valid_i & rx_last;
   // Standard frames left-aligned into bytes 0 and 1
   assign rx_aligned = (rx_len_eff == `EXT_FIELD_LEN) ? rx_shift_next :
                       {rx_shift_next[12:0], {`STD_PAD_BITS{1'b0}}};

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_shift_reg <= 32'h0000_0000;
         rx_count_reg <= 6'h00;
         rx_len_reg <= `EXT_FIELD_LEN;
         rx_busy_reg <= 1'b0;
      end else if (ce_i) begin
         if (rx_start_i) begin
            rx_count_reg <= 6'h00;
            rx_len_reg <= `EXT_FIELD_LEN;
            rx_busy_reg <= 1'b1;
         end else if (rx_busy_reg & rx_bit_valid_i) begin
            rx_shift_reg <= rx_shift_next;
            rx_count_reg <= rx_count_reg + 6'h01;
            // Thirteenth bit is the extension flag
            if ((rx_count_reg + 6'h01) == `IDE_POS_IN_FIELD) begin
               rx_len_reg <= (rx_bit_i == `IDE_EXTENDED) ?
                             `EXT_FIELD_LEN : `STD_FIELD_LEN;
            end
            if (rx_last) begin
               rx_busy_reg <= 1'b0;
            end
         end
      end
   end

   // Received identifier, kept while full; no reset value
   always @(posedge sys_clk_i) begin
      if (ce_i & rx_done & ~rx_full_o) begin
         rx_id_reg <= rx_aligned;
      end
   end

   // Full flag, frame completion wins over release
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_full_o <= 1'b0;
      end else if (ce_i) begin
         if (rx_done & ~rx_full_o) begin
            rx_full_o <= 1'b1;
         end else if (rx_release) begin
            rx_full_o <= 1'b0;
         end
      end
   end

endmodule // can_ext_id_buffer

`default_nettype wire

// file: tb/can_ext_id_checker.sv
`default_nettype none
module can_ext_id_checker (
   input wire sys_clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire tx_start_i,
   input wire tx_shift_i,
   input wire tx_bus_bit_i,
   input wire tx_done_i,
   input wire tx_request_o,
   input wire tx_bit_o,
   input wire tx_last_o,
   input wire tx_active_o,
   input wire arb_lost_o,
   input wire rx_bit_valid_i,
   input wire rx_full_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] shifts_reg;
   wire sh = tx_shift_i && tx_active_o;
   wire lose = sh && tx_bit_o && !tx_bus_bit_i;
   wire win = sh && !lose;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) shifts_reg <= 6'h00;
      else if (ce_i && tx_start_i && !tx_active_o) shifts_reg <= 6'h00;
      else if (ce_i && sh) shifts_reg <= shifts_reg + 6'h01;
   end
   // ****************
   // Assertions
   // ****************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i || !ce_i);
   chk_start_refused: assert property (tx_start_i && !tx_request_o && !tx_active_o |=> !tx_active_o)
      else $error("start taken unqueued");
   chk_bit_advance: assert property (win && !tx_last_o |=> tx_active_o) else $error("field cut short");
   chk_field_end: assert property (win && tx_last_o |=> !tx_active_o && tx_bit_o) else $error("field end");
   chk_field_len: assert property (sh && tx_last_o |-> shifts_reg == 6'h1f || shifts_reg == 6'h0c)
      else $error("field length");
   chk_lose_recessive: assert property (lose |=> !tx_active_o && arb_lost_o && tx_request_o)
      else $error("arbitration loss");
   chk_lost_cause: assert property ($rose(arb_lost_o) |-> $past(lose)) else $error("spurious loss");
   chk_done_drop: assert property (tx_done_i && tx_request_o |=> !tx_request_o) else $error("done ignored");
   chk_full_cause: assert property ($rose(rx_full_o) |-> $past(rx_bit_valid_i)) else $error("spurious full");
endmodule // can_ext_id_checker
bind can_ext_id_buffer can_ext_id_checker i_chk (.*);
`default_nettype wire

// file: tb/can_engine_model.sv
`default_nettype none
module can_engine_model (
   input wire logic sys_clk_i,
   input wire logic tx_bit_o,
   input wire logic tx_active_o,
   output logic tx_start_i,
   output logic tx_shift_i,
   output logic tx_bus_bit_i,
   output logic tx_done_i,
   output logic rx_start_i,
   output logic rx_bit_valid_i,
   output logic rx_bit_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lose_reg;
   logic [31:0] cap;
   int n;
   // Wired-and bus: a rival's dominant bit wins
   assign tx_bus_bit_i = tx_bit_o && !lose_reg;
   initial {tx_start_i, tx_shift_i, tx_done_i, rx_start_i, rx_bit_valid_i, rx_bit_i, lose_reg} = '0;
   task automatic send_tx(input int lose_at);
      int k;
      cap = '0;
      n = 0;
      @(posedge sys_clk_i);
      tx_start_i <= 1'b1;
      @(posedge sys_clk_i);
      tx_start_i <= 1'b0;
      for (k = 0; k < 80; k++) begin
         @(posedge sys_clk_i);
         if (tx_shift_i) begin
            cap = {cap[30:0], tx_bit_o};
            n++;
            tx_shift_i <= 1'b0;
            lose_reg <= 1'b0;
         end else if (tx_active_o === 1'b1) begin
            tx_shift_i <= 1'b1;
            lose_reg <= (n == lose_at);
         end else break;
      end
      if (lose_at < 0) begin
         @(posedge sys_clk_i);
         tx_done_i <= 1'b1;
         @(posedge sys_clk_i);
         tx_done_i <= 1'b0;
      end
   endtask
   // Bits go out first-to-last as on the bus
   task automatic send_rx(input logic [31:0] f, input int len);
      int k;
      @(posedge sys_clk_i);
      rx_start_i <= 1'b1;
      for (k = len - 1; k >= 0; k--) begin
         @(posedge sys_clk_i);
         rx_start_i <= 1'b0;
         rx_bit_valid_i <= 1'b1;
         rx_bit_i <= f[k];
      end
      @(posedge sys_clk_i);
      rx_bit_valid_i <= 1'b0;
      rx_bit_i <= !f[0];
   endtask
endmodule // can_engine_model
`default_nettype wire

// file: tb/tb_can_ext_id_buffer.sv
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_can_ext_id_buffer;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i, rst_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, tx_last_o, tx_start_i;
   logic tx_shift_i, tx_bus_bit_i, tx_done_i, tx_request_o, tx_bit_o, tx_active_o, arb_lost_o;
   logic rx_start_i, rx_bit_valid_i, rx_bit_i, rx_full_o;
   logic [3:0] avs_byteenable_i;
   logic [5:0] avs_address_i;
   logic [7:0] q;
   logic [31:0] avs_writedata_i, avs_readdata_o, f, w;
   int n_errors = 0;
   int tests_run = 0;
   int i, b;
   can_ext_id_buffer i_dut (.*);
   can_engine_model i_eng (.*);
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = !sys_clk_i;
   end
   function automatic logic [31:0] fld(input logic ide, input logic [28:0] id, input logic rtr);
      fld = ide ? {id[28:18], 2'b11, id[17:0], rtr} : {19'h00000, id[10:0], rtr, 1'b0};
   endfunction
   task automatic close_out();
      if (n_errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
      int k;
      @(posedge sys_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= {24'h000000, d};
      avs_write_i <= wr;
      avs_read_i <= !wr;
      for (k = 0; k < 20 && avs_waitrequest_o !== 1'b0; k++) @(posedge sys_clk_i);
      if (k == 20) begin
         n_errors++;
         close_out();
      end
      q = avs_readdata_o[7:0];
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHK(q, e)
   endtask
   initial begin
      {rst_i, ce_i} = 2'b11;
      {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
      avs_byteenable_i = 4'h1;
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(6'h24, 8'h01);
      rd(6'h3c, 8'h00);
      bus(1'b1, 6'h20, 8'h02);
      for (i = 0; i < 3; i++) begin
         f = fld(i != 1, i == 0 ? 29'h12345678 : 29'h000005a3, i == 0);
         w = (i == 1) ? f << 19 : f;
         for (b = 0; b < 4; b++) bus(1'b1, 6'(b * 4), w[31 - 8 * b -: 8]);
         for (b = 0; b < 4; b++) rd(6'(b * 4), w[31 - 8 * b -: 8]);
         bus(1'b1, 6'h20, 8'h03);
         i_eng.send_tx(i == 2 ? 11 : -1);
         if (i == 2) begin
            `CHK(i_eng.n, 12)
            rd(6'h24, 8'h04);
            bus(1'b1, 6'h20, 8'h0a);
            i_eng.send_tx(-1);
         end
         `CHK(i_eng.cap, f)
         `CHK(i_eng.n, i == 1 ? 13 : 32)
         rd(6'h24, 8'h01);
      end
      bus(1'b1, 6'h20, 8'h00);
      bus(1'b1, 6'h20, 8'h01);
      bus(1'b1, 6'h00, 8'ha5);
      rd(6'h00, w[31:24]);
      i_eng.send_tx(-1);
      `CHK(i_eng.n, 0)
      for (i = 0; i < 2; i++) begin
         f = i ? fld(1'b0, 29'h00000412, 1'b1) : fld(1'b1, 29'h0abcdef1, 1'b1) & 32'hffefffff;
         w = i ? f << 19 : f;
         i_eng.send_rx(f, i ? 13 : 32);
         rd(6'h24, 8'h03);
         for (b = 0; b < 4; b++) rd(6'(16 + b * 4), w[31 - 8 * b -: 8]);
         bus(1'b1, 6'h20, 8'h04);
      end
      close_out();
   end
endmodule // tb_can_ext_id_buffer
`default_nettype wire
